// >>> fsal_top.v
/*
 * Flash protection and mapping: scratchpad overlay, software write and
 * erase gating, JTAG lock bytes and the software read limit.
 * Assumes CPU, JTAG host and flash array run on core_clk_in; the JTAG
 * host is already synchronised to this clock upstream.
 */
`timescale 1ns/1ps
`include "fsal_consts.vh"

module fsal_top (
	input  wire        core_clk_in,      // System clock
	input  wire        rst_in,           // Async reset, active high
	input  wire        en_in,            // Clock enable, freezes all
	input  wire [7:0]  sfr_addr_in,      // Register address
	input  wire        sfr_wr_in,        // Register write strobe
	input  wire [7:0]  sfr_wdata_in,     // Register write data
	output reg  [7:0]  sfr_rdata_out,    // Register read data
	input  wire        cpu_req_in,       // CPU flash request pulse
	input  wire [1:0]  cpu_kind_in,      // Fetch, MOVC read, MOVX write
	input  wire [15:0] cpu_pc_in,        // PC of issuing instruction
	input  wire [15:0] cpu_addr_in,      // Target address
	input  wire [7:0]  cpu_wdata_in,     // MOVX write data
	output reg         cpu_ready_out,    // Block idle, CPU may ask
	output reg         cpu_ack_out,      // CPU answer pulse
	output reg         cpu_blocked_out,  // CPU access was refused
	output reg  [7:0]  cpu_rdata_out,    // CPU read data
	output reg         debug_denied_out, // PC sits in read-locked block
	input  wire        jtag_req_in,      // JTAG request pulse
	input  wire [1:0]  jtag_op_in,       // Read, write, erase
	input  wire        jtag_scratch_in,  // Target is the scratchpad
	input  wire [15:0] jtag_addr_in,     // Target address
	input  wire [7:0]  jtag_wdata_in,    // Write data
	output reg         jtag_ready_out,   // Block idle, JTAG may ask
	output reg         jtag_ack_out,     // JTAG answer pulse
	output reg         jtag_refused_out, // JTAG access refused
	output reg  [7:0]  jtag_rdata_out,   // JTAG read data
	output reg         fl_req_out,       // Flash command pulse
	output reg  [1:0]  fl_op_out,        // Flash operation
	output reg         fl_scratch_out,   // Scratchpad sector selected
	output reg  [15:0] fl_addr_out,      // Flash address
	output reg  [7:0]  fl_wdata_out,     // Flash write data
	input  wire        fl_done_in,       // Flash operation finished
	input  wire [7:0]  fl_rdata_in       // Flash read data
);

	// State codes
	localparam [2:0] S_LREQ = 3'h0; // Issue lock byte read
	localparam [2:0] S_LWAIT = 3'h1; // Wait lock byte read
	localparam [2:0] S_IDLE = 3'h2; // Accept requests
	localparam [2:0] S_BUSY = 3'h3; // Wait flash operation

	reg  [2:0]  state_q;        // Sequencer state
	reg  [2:0]  state_d;        // Next state
	reg         lsel_q;         // 0 loading read lock, 1 write lock
	reg         who_q;          // 1 when JTAG owns the flash
	reg  [2:0]  store_ctrl_q;   // Program store control bits
	reg  [7:0]  flash_ctrl_q;   // Flash control bits
	reg  [7:0]  limit_q;        // Access limit register
	reg         limit_set_q;    // Limit already written
	wire [7:0]  rd_lock;        // Read lock byte copy
	wire [7:0]  we_lock;        // Write/erase lock byte copy
	wire [15:0] limit_addr;     // Software read limit

	// Decision signals
	reg         cpu_go;         // CPU access goes to flash
	reg  [1:0]  cpu_op;         // Its flash operation
	reg         cpu_scr;        // Its scratchpad select
	reg         jtag_go;        // JTAG access goes to flash
	reg  [1:0]  jtag_op;        // Its flash operation
	reg         cpu_low;        // Target in lower partition
	reg         cpu_upper;      // Code in upper partition
	reg         jtag_ok;        // JTAG block permission
	reg         iss;            // Flash command issued now
	reg  [1:0]  iss_op;         // Issued operation
	reg         iss_scr;        // Issued scratchpad flag
	reg  [15:0] iss_addr;       // Issued address
	reg  [7:0]  iss_data;       // Issued data
	wire        take_jtag;      // JTAG request taken
	wire        take_cpu;       // CPU request taken
	wire        lk_load;        // Lock byte arrives from flash
	wire        lk_erase;       // Issued erase covers lock bytes

	// True for either security byte
	function is_sec;
		input [15:0] a;
		begin
			is_sec = (a[15:1] == `FSAL_SEC_PAIR);
		end
	endfunction

	// True inside the 512-byte page holding the lock bytes
	function in_lock_page;
		input [15:0] a;
		begin
			in_lock_page = (a[15:9] == `FSAL_LOCK_PAGE);
		end
	endfunction

	assign limit_addr = {limit_q, 8'h00};
	assign take_jtag  = (state_q == S_IDLE) && jtag_req_in;
	// JTAG wins a tie; the CPU request is dropped
	assign take_cpu   = (state_q == S_IDLE) && !jtag_req_in && cpu_req_in;
	assign lk_load    = (state_q == S_LWAIT) && fl_done_in;
	assign lk_erase   = iss && !iss_scr && ((iss_op == `FSAL_FL_ERASE_ALL) ||
	                    ((iss_op == `FSAL_FL_ERASE_PAGE) && in_lock_page(iss_addr)));

	// Lock byte copy, kept in step with flash contents
	fsal_lock_store u_lock (
		.core_clk_in  (core_clk_in),
		.rst_in       (rst_in),
		.en_in        (en_in),
		.load_rd_in   (lk_load && !lsel_q),
		.load_we_in   (lk_load && lsel_q),
		.load_data_in (fl_rdata_in),
		.wr_in        (iss && !iss_scr && (iss_op == `FSAL_FL_WRITE)),
		.wr_addr_in   (iss_addr),
		.wr_data_in   (iss_data),
		.erase_in     (lk_erase),
		.rd_lock_out  (rd_lock),
		.we_lock_out  (we_lock)
	);

	// CPU access classification
	always @* begin
		cpu_scr = store_ctrl_q[`FSAL_BIT_SCRATCH_SEL] &&
		          (cpu_kind_in != `FSAL_CPU_FETCH);
		cpu_low   = !cpu_scr && (cpu_addr_in < limit_addr);
		cpu_upper = (cpu_pc_in >= limit_addr);
		cpu_op    = `FSAL_FL_READ;
		cpu_go    = 1'b0;
		case (cpu_kind_in)
			`FSAL_CPU_FETCH: begin
				// Execution is never limited by partition
				cpu_go = 1'b1;
			end
			`FSAL_CPU_MOVC_RD: begin
				cpu_go = !(cpu_upper && cpu_low);
			end
			`FSAL_CPU_MOVX_WR: begin
				cpu_op = store_ctrl_q[`FSAL_BIT_STORE_EE] ?
				         `FSAL_FL_ERASE_PAGE : `FSAL_FL_WRITE;
				cpu_go = store_ctrl_q[`FSAL_BIT_STORE_WE] &&
				         flash_ctrl_q[`FSAL_BIT_WRITE_UNLOCK] &&
				         !(cpu_upper && cpu_low);
				// Lock page erase from software is ignored
				if (store_ctrl_q[`FSAL_BIT_STORE_EE] && !cpu_scr &&
				    in_lock_page(cpu_addr_in)) begin
					cpu_go = 1'b0;
				end
			end
			default: begin
				cpu_go = 1'b0;
			end
		endcase
	end

	// JTAG access classification against the lock bytes
	always @* begin
		jtag_op = `FSAL_FL_READ;
		jtag_ok = 1'b0;
		jtag_go = 1'b0;
		case (jtag_op_in)
			`FSAL_JTAG_READ: begin
				// Scratchpad falls only when every block is locked
				jtag_ok = jtag_scratch_in ? (rd_lock != 8'h00) :
				          (rd_lock[jtag_addr_in[15:13]] ||
				           is_sec(jtag_addr_in));
				jtag_go = jtag_ok;
			end
			`FSAL_JTAG_WRITE: begin
				jtag_op = `FSAL_FL_WRITE;
				jtag_ok = jtag_scratch_in ? (we_lock != 8'h00) :
				          (we_lock[jtag_addr_in[15:13]] ||
				           is_sec(jtag_addr_in));
				jtag_go = jtag_ok;
			end
			`FSAL_JTAG_ERASE: begin
				jtag_op = `FSAL_FL_ERASE_PAGE;
				if (jtag_scratch_in) begin
					jtag_go = (we_lock != 8'h00);
				end else if (is_sec(jtag_addr_in)) begin
					// Full erase always frees a lock; a lock page erase does too when we_lock[7] is set
					jtag_op = `FSAL_FL_ERASE_ALL;
					jtag_go = 1'b1;
				end else if (in_lock_page(jtag_addr_in)) begin
					jtag_go = we_lock[7];
				end else begin
					jtag_go = we_lock[jtag_addr_in[15:13]];
				end
			end
			default: begin
				jtag_go = 1'b0;
			end
		endcase
	end

	// Command selection and next state
	always @* begin
		iss      = 1'b0;
		iss_op   = jtag_op;
		iss_scr  = jtag_scratch_in;
		iss_addr = jtag_addr_in;
		iss_data = jtag_wdata_in;
		state_d  = state_q;
		if (take_jtag) begin
			iss = jtag_go;
		end else if (take_cpu) begin
			iss      = cpu_go;
			iss_op   = cpu_op;
			iss_scr  = cpu_scr;
			iss_data = cpu_wdata_in;
			// Scratchpad keeps only the low seven address bits
			iss_addr = cpu_scr ? (cpu_addr_in & `FSAL_SCRATCH_TOP) : cpu_addr_in;
		end
		case (state_q)
			S_LREQ:  state_d = S_LWAIT;
			S_LWAIT: state_d = fl_done_in ? (lsel_q ? S_IDLE : S_LREQ) : S_LWAIT;
			S_IDLE:  state_d = iss ? S_BUSY : S_IDLE;
			S_BUSY:  state_d = fl_done_in ? S_IDLE : S_BUSY;
			default: state_d = S_LREQ;
		endcase
	end

	// Sequencer, flash command and answers
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q          <= S_LREQ;
			lsel_q           <= 1'b0;
			who_q            <= 1'b0;
			cpu_ready_out    <= 1'b0;
			cpu_ack_out      <= 1'b0;
			cpu_blocked_out  <= 1'b0;
			cpu_rdata_out    <= 8'h00;
			debug_denied_out <= 1'b0;
			jtag_ready_out   <= 1'b0;
			jtag_ack_out     <= 1'b0;
			jtag_refused_out <= 1'b0;
			jtag_rdata_out   <= 8'h00;
			fl_req_out       <= 1'b0;
			fl_op_out        <= `FSAL_FL_READ;
			fl_scratch_out   <= 1'b0;
			fl_addr_out      <= 16'h0000;
			fl_wdata_out     <= 8'h00;
		end else if (en_in) begin
			state_q          <= state_d;
			cpu_ready_out    <= (state_d == S_IDLE);
			jtag_ready_out   <= (state_d == S_IDLE);
			cpu_ack_out      <= 1'b0;
			cpu_blocked_out  <= 1'b0;
			jtag_ack_out     <= 1'b0;
			jtag_refused_out <= 1'b0;
			fl_req_out       <= 1'b0;
			// Debug halts are denied inside read-locked blocks
			debug_denied_out <= !rd_lock[cpu_pc_in[15:13]];
			if (state_q == S_LREQ) begin
				// Lock settings come from flash itself
				fl_req_out     <= 1'b1;
				fl_op_out      <= `FSAL_FL_READ;
				fl_scratch_out <= 1'b0;
				fl_addr_out    <= lsel_q ? `FSAL_ADDR_WRITE_LOCK : `FSAL_ADDR_READ_LOCK;
			end
			if (lk_load) begin
				lsel_q <= 1'b1;
			end
			if (iss) begin
				fl_req_out     <= 1'b1;
				fl_op_out      <= iss_op;
				fl_scratch_out <= iss_scr;
				fl_addr_out    <= iss_addr;
				fl_wdata_out   <= iss_data;
				who_q          <= take_jtag;
			end else if (take_jtag) begin
				// Refused reads give no flash content at all
				jtag_ack_out     <= 1'b1;
				jtag_refused_out <= 1'b1;
				jtag_rdata_out   <= 8'h00;
			end else if (take_cpu) begin
				cpu_ack_out     <= 1'b1;
				cpu_blocked_out <= 1'b1;
				cpu_rdata_out   <= 8'h00;
			end
			if ((state_q == S_BUSY) && fl_done_in) begin
				if (who_q) begin
					jtag_ack_out   <= 1'b1;
					jtag_rdata_out <= fl_rdata_in;
				end else begin
					cpu_ack_out   <= 1'b1;
					cpu_rdata_out <= fl_rdata_in;
				end
			end
		end
	end

	// Register file; read data lags the address by one cycle
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			store_ctrl_q  <= `FSAL_RST_STORE_CTRL;
			flash_ctrl_q  <= `FSAL_RST_FLASH_CTRL;
			limit_q       <= `FSAL_RST_ACCESS_LIMIT;
			limit_set_q   <= 1'b0;
			sfr_rdata_out <= 8'h00;
		end else if (en_in) begin
			if (sfr_wr_in) begin
				case (sfr_addr_in)
					`FSAL_OFS_STORE_CTRL: begin
						store_ctrl_q <= sfr_wdata_in[2:0];
					end
					`FSAL_OFS_FLASH_CTRL: begin
						flash_ctrl_q <= sfr_wdata_in & `FSAL_FLASH_CTRL_MASK;
					end
					`FSAL_OFS_ACCESS_LIMIT: begin
						// Later writes cannot loosen the partition
						if (!limit_set_q) begin
							limit_q     <= sfr_wdata_in;
							limit_set_q <= 1'b1;
						end
					end
					default: begin
						limit_set_q <= limit_set_q;
					end
				endcase
			end
			case (sfr_addr_in)
				`FSAL_OFS_STORE_CTRL:   sfr_rdata_out <= {5'h00, store_ctrl_q};
				`FSAL_OFS_FLASH_CTRL:   sfr_rdata_out <= flash_ctrl_q;
				`FSAL_OFS_ACCESS_LIMIT: sfr_rdata_out <= limit_q;
				default:                sfr_rdata_out <= 8'h00;
			endcase
		end
	end

endmodule

// >>> fsal_consts.vh
/*
 * Constants for the flash security and access-limit block: register
 * offsets, bit positions, reset values, address landmarks and codes.
 * Assumes it is included by bare name from each design file.
 */
`ifndef FSAL_CONSTS_VH
`define FSAL_CONSTS_VH

// Register offsets on the special-function register port
`define FSAL_OFS_STORE_CTRL    8'h8f
`define FSAL_OFS_FLASH_CTRL    8'hb6
`define FSAL_OFS_ACCESS_LIMIT  8'hb7

// Program store control bit positions
`define FSAL_BIT_STORE_WE      0
`define FSAL_BIT_STORE_EE      1
`define FSAL_BIT_SCRATCH_SEL   2

// Flash control unlock bit and implemented bits; register reset values
`define FSAL_BIT_WRITE_UNLOCK  0
`define FSAL_FLASH_CTRL_MASK   8'hc1
`define FSAL_RST_FLASH_CTRL    8'h80
`define FSAL_RST_STORE_CTRL    3'h0
`define FSAL_RST_ACCESS_LIMIT  8'h00

// Lock bytes and their page
`define FSAL_ADDR_READ_LOCK    16'hfdff
`define FSAL_ADDR_WRITE_LOCK   16'hfdfe
`define FSAL_SEC_PAIR          15'h7eff
`define FSAL_LOCK_PAGE         7'h7e
`define FSAL_RST_LOCK          8'h00
`define FSAL_ERASED_BYTE       8'hff
`define FSAL_SCRATCH_TOP       16'h007f

// CPU access kinds
`define FSAL_CPU_FETCH         2'h0
`define FSAL_CPU_MOVC_RD       2'h1
`define FSAL_CPU_MOVX_WR       2'h2

// JTAG operations
`define FSAL_JTAG_READ         2'h0
`define FSAL_JTAG_WRITE        2'h1
`define FSAL_JTAG_ERASE        2'h2

// Flash array operations
`define FSAL_FL_READ           2'h0
`define FSAL_FL_WRITE          2'h1
`define FSAL_FL_ERASE_PAGE     2'h2
`define FSAL_FL_ERASE_ALL      2'h3

`endif

// >>> fsal_lock_store.v
/*
 * Holds the read lock byte and the write/erase lock byte as they stand
 * in flash. Loaded from flash after reset, then tracked as writes clear
 * bits and erases set them.
 * Assumes the caller loads both bytes before granting any JTAG access.
 */
`timescale 1ns/1ps
`include "fsal_consts.vh"

module fsal_lock_store (
	input  wire       core_clk_in,   // System clock
	input  wire       rst_in,        // Async reset, active high
	input  wire       en_in,         // Clock enable
	input  wire       load_rd_in,    // Load read lock byte
	input  wire       load_we_in,    // Load write/erase lock byte
	input  wire [7:0] load_data_in,  // Byte read from flash
	input  wire       wr_in,         // Byte write issued to flash
	input  wire [15:0] wr_addr_in,   // Address of that write
	input  wire [7:0] wr_data_in,    // Data of that write
	input  wire       erase_in,      // Erase covering the lock bytes
	output reg  [7:0] rd_lock_out,   // Read lock byte
	output reg  [7:0] we_lock_out    // Write/erase lock byte
);

	// Copy follows flash: writes only clear, erase sets all
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			// All locked until loaded, so nothing leaks early
			rd_lock_out <= `FSAL_RST_LOCK;
			we_lock_out <= `FSAL_RST_LOCK;
		end else if (en_in) begin
			if (erase_in) begin
				rd_lock_out <= `FSAL_ERASED_BYTE;
				we_lock_out <= `FSAL_ERASED_BYTE;
			end else if (load_rd_in) begin
				rd_lock_out <= load_data_in;
			end else if (load_we_in) begin
				we_lock_out <= load_data_in;
			end else if (wr_in) begin
				// Flash cells can only go 1 to 0 on a write
				if (wr_addr_in == `FSAL_ADDR_READ_LOCK) begin
					rd_lock_out <= rd_lock_out & wr_data_in;
				end
				if (wr_addr_in == `FSAL_ADDR_WRITE_LOCK) begin
					we_lock_out <= we_lock_out & wr_data_in;
				end
			end
		end
	end

endmodule

// >>> fsal_flash_model.sv
/* Behavioural flash array for fsal_top: writes clear bits, erases set
   them, one command at a time. Assumes commands come as single pulses. */
`timescale 1ns/1ps
`include "fsal_consts.vh"
module fsal_flash_model (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        slow_in,
	input  wire        req_in,
	input  wire [1:0]  op_in,
	input  wire        scratch_in,
	input  wire [15:0] addr_in,
	input  wire [7:0]  wdata_in,
	output reg         done_out,
	output reg  [7:0]  rdata_out
);
	reg [7:0]  mem [0:65535]; // Main array
	reg [7:0]  spad [0:127];  // Scratchpad sector
	reg [2:0]  cnt;           // Cycles to answer
	reg [1:0]  op;            // Held command
	reg        sc;            // Held sector select
	reg [15:0] a;             // Held address
	reg [7:0]  wd;            // Held data
	integer    i;
	// Pattern content; lock bytes lock block 0 reads, top block writes
	initial begin
		for (i = 0; i < 65536; i = i + 1) mem[i] = i[7:0] ^ i[15:8];
		for (i = 0; i < 128; i = i + 1) spad[i] = 8'hff;
		mem[`FSAL_ADDR_READ_LOCK] = 8'hfe;
		mem[`FSAL_ADDR_WRITE_LOCK] = 8'h7f;
	end
	// Idle data toggles so stale bytes never look valid
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 3'h0;
			done_out <= 1'h0;
			rdata_out <= 8'h5a;
		end else if (req_in) begin
			op <= op_in;
			sc <= scratch_in;
			a <= addr_in;
			wd <= wdata_in;
			cnt <= slow_in ? 3'h4 : 3'h1; // Prompt or slow answer
			done_out <= 1'h0;
			rdata_out <= ~rdata_out;
		end else if (cnt == 3'h1) begin
			cnt <= 3'h0;
			done_out <= 1'h1;
			case (op)
			`FSAL_FL_READ: rdata_out <= sc ? spad[a[6:0]] : mem[a];
			`FSAL_FL_WRITE: begin
				if (sc) spad[a[6:0]] <= spad[a[6:0]] & wd;
				else mem[a] <= mem[a] & wd;
			end
			`FSAL_FL_ERASE_PAGE: begin
				for (i = 0; i < 512; i = i + 1)
					if (sc) spad[i[6:0]] <= 8'hff;
					else mem[{a[15:9], i[8:0]}] <= 8'hff;
			end
			default: for (i = 0; i < 65536; i = i + 1) mem[i] <= 8'hff;
			endcase
		end else begin
			if (cnt != 3'h0) cnt <= cnt - 3'h1;
			done_out <= 1'h0;
			rdata_out <= ~rdata_out;
		end
	end
endmodule

// >>> fsal_monitor.sv
/* Checker for fsal_top ports, bound into every instance.
   Assumes en_in stays high; register shadows follow the write port. */
`timescale 1ns/1ps
`include "fsal_consts.vh"
module fsal_monitor (
	input wire        core_clk_in,
	input wire        rst_in,
	input wire        en_in,
	input wire [7:0]  sfr_addr_in,
	input wire        sfr_wr_in,
	input wire [7:0]  sfr_wdata_in,
	input wire [7:0]  sfr_rdata_out,
	input wire        cpu_req_in,
	input wire [1:0]  cpu_kind_in,
	input wire [15:0] cpu_pc_in,
	input wire [15:0] cpu_addr_in,
	input wire        cpu_ready_out,
	input wire        cpu_ack_out,
	input wire        cpu_blocked_out,
	input wire [7:0]  cpu_rdata_out,
	input wire        jtag_req_in,
	input wire [1:0]  jtag_op_in,
	input wire        jtag_scratch_in,
	input wire [15:0] jtag_addr_in,
	input wire        jtag_ready_out,
	input wire        jtag_ack_out,
	input wire        jtag_refused_out,
	input wire [7:0]  jtag_rdata_out,
	input wire        fl_req_out,
	input wire [1:0]  fl_op_out,
	input wire        fl_scratch_out
);
	reg  [2:0] ctrl_q;  // Store control shadow
	reg        unl_q;   // Write unlock shadow
	reg  [7:0] lim_q;   // Access limit shadow
	reg        set_q;   // Limit already written
	wire cpu_tk = en_in && cpu_req_in && cpu_ready_out && !jtag_req_in;
	wire jt_tk  = en_in && jtag_req_in && jtag_ready_out;
	wire [15:0] lim = {lim_q, 8'h00};
	// Shadow registers; the limit takes only its first write
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q <= 3'h0;
			unl_q <= 1'h0;
			lim_q <= 8'h00;
			set_q <= 1'h0;
		end else if (en_in && sfr_wr_in) begin
			if (sfr_addr_in == `FSAL_OFS_STORE_CTRL) ctrl_q <= sfr_wdata_in[2:0];
			if (sfr_addr_in == `FSAL_OFS_FLASH_CTRL) unl_q <= sfr_wdata_in[0];
			if (sfr_addr_in == `FSAL_OFS_ACCESS_LIMIT && !set_q) begin
				lim_q <= sfr_wdata_in;
				set_q <= 1'h1;
			end
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	cpu_refusal_a: assert property (cpu_blocked_out |-> cpu_ack_out && cpu_rdata_out == 8'h00)
		else $error("CPU refusal without ack or with data");
	jtag_refusal_a: assert property (jtag_refused_out |-> jtag_ack_out && jtag_rdata_out == 8'h00)
		else $error("JTAG refusal without ack or with data");
	fetch_plain_a: assert property (cpu_tk && cpu_kind_in == `FSAL_CPU_FETCH
		|=> fl_req_out && fl_op_out == `FSAL_FL_READ && !fl_scratch_out) else $error("Fetch misrouted");
	store_gate_a: assert property (cpu_tk && cpu_kind_in == `FSAL_CPU_MOVX_WR && !(ctrl_q[0] && unl_q)
		|=> cpu_ack_out && cpu_blocked_out) else $error("Store write not blocked");
	limit_block_a: assert property (cpu_tk && cpu_kind_in == `FSAL_CPU_MOVC_RD && !ctrl_q[2] &&
		cpu_pc_in >= lim && cpu_addr_in < lim |=> cpu_blocked_out) else $error("Limit not enforced");
	lower_free_a: assert property (cpu_tk && cpu_kind_in == `FSAL_CPU_MOVC_RD && cpu_pc_in < lim
		|=> fl_req_out && !cpu_ack_out) else $error("Lower code read refused");
	limit_once_a: assert property ($past(sfr_addr_in) == `FSAL_OFS_ACCESS_LIMIT
		|-> sfr_rdata_out == $past(lim_q)) else $error("Access limit readback wrong");
	erase_all_a: assert property (jt_tk && jtag_op_in == `FSAL_JTAG_ERASE && !jtag_scratch_in &&
		jtag_addr_in[15:1] == `FSAL_SEC_PAIR |=> fl_req_out && fl_op_out == `FSAL_FL_ERASE_ALL)
		else $error("Lock byte erase not full");
	lock_page_a: assert property (cpu_tk && cpu_kind_in == `FSAL_CPU_MOVX_WR && ctrl_q == 3'h3 &&
		unl_q && cpu_addr_in[15:9] == `FSAL_LOCK_PAGE |=> cpu_blocked_out) else $error("Lock page erased");
	cover property (cpu_blocked_out);
	cover property (jtag_refused_out);
	cover property (fl_req_out && fl_op_out == `FSAL_FL_ERASE_ALL);
endmodule
bind fsal_top fsal_monitor mon_u (.core_clk_in, .rst_in, .en_in, .sfr_addr_in, .sfr_wr_in,
	.sfr_wdata_in, .sfr_rdata_out, .cpu_req_in, .cpu_kind_in, .cpu_pc_in, .cpu_addr_in,
	.cpu_ready_out, .cpu_ack_out, .cpu_blocked_out, .cpu_rdata_out, .jtag_req_in, .jtag_op_in,
	.jtag_scratch_in, .jtag_addr_in, .jtag_ready_out, .jtag_ack_out, .jtag_refused_out,
	.jtag_rdata_out, .fl_req_out, .fl_op_out, .fl_scratch_out);

// >>> tb_flash_security_access_limit.sv
/* Self-checking bench for fsal_top with the flash model behind it.
   Assumes model lock bytes 0xfe (read) and 0x7f (write/erase). */
`timescale 1ns/1ps
`include "fsal_consts.vh"
`define CK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("Error %0t: got %h expected %h", $time, g, e); end end
module tb_flash_security_access_limit;
	localparam [1:0] RD = `FSAL_JTAG_READ, WR = `FSAL_JTAG_WRITE, ER = `FSAL_JTAG_ERASE;
	localparam [1:0] FE = `FSAL_CPU_FETCH, MC = `FSAL_CPU_MOVC_RD, MX = `FSAL_CPU_MOVX_WR;
	localparam T = 1'h1, F = 1'h0;
	localparam [8:0] DC = 9'h100; // Read data not checked
	reg         core_clk_in = 1'h0, rst_in = 1'h1, sfr_wr_in = 1'h0, slow_q = 1'h0;
	reg         cpu_req_in = 1'h0, jtag_req_in = 1'h0, jtag_scratch_in = 1'h0;
	reg  [7:0]  sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, cpu_wdata_in = 8'h00, jtag_wdata_in = 8'h00;
	reg  [1:0]  cpu_kind_in = 2'h0, jtag_op_in = 2'h0;
	reg  [15:0] cpu_pc_in = 16'h0, cpu_addr_in = 16'h0, jtag_addr_in = 16'h0;
	wire [7:0]  sfr_rdata_out, cpu_rdata_out, jtag_rdata_out, fl_wdata_out, fl_rdata_in;
	wire        cpu_ready_out, cpu_ack_out, cpu_blocked_out, jtag_ready_out, jtag_ack_out;
	wire        jtag_refused_out, fl_req_out, fl_scratch_out, fl_done_in, debug_denied_out;
	wire [1:0]  fl_op_out;
	wire [15:0] fl_addr_out;
	integer     err_count = 0, compares = 0;
	// 100 MHz clock
	always #5 core_clk_in = ~core_clk_in;
	// Clock enable tied high: freeze logic is not exercised
	fsal_top dut_u (.core_clk_in, .rst_in, .en_in(1'h1), .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in,
		.sfr_rdata_out, .cpu_req_in, .cpu_kind_in, .cpu_pc_in, .cpu_addr_in, .cpu_wdata_in,
		.cpu_ready_out, .cpu_ack_out, .cpu_blocked_out, .cpu_rdata_out, .debug_denied_out,
		.jtag_req_in, .jtag_op_in, .jtag_scratch_in, .jtag_addr_in, .jtag_wdata_in,
		.jtag_ready_out, .jtag_ack_out, .jtag_refused_out, .jtag_rdata_out, .fl_req_out,
		.fl_op_out, .fl_scratch_out, .fl_addr_out, .fl_wdata_out, .fl_done_in, .fl_rdata_in);
	fsal_flash_model flash_u (.clk_in(core_clk_in), .rst_in(rst_in), .slow_in(slow_q),
		.req_in(fl_req_out), .op_in(fl_op_out), .scratch_in(fl_scratch_out), .addr_in(fl_addr_out),
		.wdata_in(fl_wdata_out), .done_out(fl_done_in), .rdata_out(fl_rdata_in));
	function [7:0] pt(input [15:0] a); // Model fill pattern
		pt = a[7:0] ^ a[15:8];
	endfunction
	task automatic report_and_stop;
		begin
			$display("Comparisons %0d, mismatches %0d", compares, err_count);
			if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	// One CPU or JTAG transfer; waits bounded, judges refusal and data
	task automatic tr(input j, input [1:0] op, input [15:0] pc, input [15:0] a, input [7:0] wd,
			input sc, input eref, input [8:0] erd);
		integer n;
		begin
			n = 0;
			while (!(j ? jtag_ready_out : cpu_ready_out) && n < 99) begin
				@(posedge core_clk_in);
				n++;
			end
			if (j) begin
				jtag_req_in <= 1'h1;
				jtag_op_in <= op;
				jtag_scratch_in <= sc;
				jtag_addr_in <= a;
				jtag_wdata_in <= wd;
			end else begin
				cpu_req_in <= 1'h1;
				cpu_kind_in <= op;
				cpu_pc_in <= pc;
				cpu_addr_in <= a;
				cpu_wdata_in <= wd;
			end
			@(posedge core_clk_in);
			cpu_req_in <= 1'h0;
			jtag_req_in <= 1'h0;
			do begin
				@(posedge core_clk_in);
				n++;
			end while (!(j ? jtag_ack_out : cpu_ack_out) && n < 99);
			if (n >= 99) begin // Hang counts as a mismatch
				err_count++;
				report_and_stop;
			end
			`CK(j ? jtag_refused_out : cpu_blocked_out, eref)
			if (!erd[8]) `CK(j ? jtag_rdata_out : cpu_rdata_out, erd[7:0])
		end
	endtask
	// Register write; extra edge keeps strobes apart
	task automatic sw(input [7:0] a, input [7:0] d);
		begin
			sfr_addr_in <= a;
			sfr_wdata_in <= d;
			sfr_wr_in <= 1'h1;
			@(posedge core_clk_in);
			sfr_wr_in <= 1'h0;
			@(posedge core_clk_in);
		end
	endtask
	task automatic rg(input [7:0] a, input [7:0] e);
		begin
			sfr_addr_in <= a;
			repeat (2) @(posedge core_clk_in);
			`CK(sfr_rdata_out, e)
		end
	endtask
	task automatic t_regs;
		begin
			rg(`FSAL_OFS_ACCESS_LIMIT, 8'h00);
			rg(`FSAL_OFS_STORE_CTRL, 8'h00);
			rg(`FSAL_OFS_FLASH_CTRL, 8'h80);
			rg(8'h00, 8'h00);
		end
	endtask
	task automatic t_jtag;
		begin
			tr(T, RD, 16'h0, 16'h0100, 8'h0, F, T, 9'h0);
			tr(T, RD, 16'h0, 16'h2100, 8'h0, F, F, pt(16'h2100));
			tr(T, RD, 16'h0, 16'hfdff, 8'h0, F, F, 9'hfe);
			tr(T, WR, 16'h0, 16'he000, 8'h0, F, T, 9'h0);
			tr(T, WR, 16'h0, 16'h2000, 8'h0f, F, F, DC);
			tr(T, RD, 16'h0, 16'h2000, 8'h0, F, F, 9'h00);
			tr(T, ER, 16'h0, 16'hfc10, 8'h0, F, T, 9'h0);
			tr(T, WR, 16'h0, 16'hfdfe, 8'h3f, F, F, DC);
			tr(T, RD, 16'h0, 16'hfdfe, 8'h0, F, F, 9'h3f);
			tr(T, RD, 16'h0, 16'h0010, 8'h0, T, F, 9'hff);
			cpu_pc_in <= 16'h0100;
			repeat (3) @(posedge core_clk_in);
			`CK(debug_denied_out, T)
			cpu_pc_in <= 16'h2000; // Block 1 is read-open
			repeat (3) @(posedge core_clk_in);
			`CK(debug_denied_out, F)
		end
	endtask
	task automatic t_sw;
		begin
			tr(F, MX, 16'h0, 16'h2000, 8'h0, F, T, DC);
			sw(`FSAL_OFS_STORE_CTRL, 8'h03);
			tr(F, MX, 16'h0, 16'h4000, 8'h0, F, T, DC);
			sw(`FSAL_OFS_FLASH_CTRL, 8'h81);
			tr(F, MX, 16'h0, 16'hfc00, 8'h0, F, T, DC);
			tr(F, MX, 16'h0, 16'h4000, 8'h0, F, F, DC);
			tr(F, MC, 16'h0, 16'h4005, 8'h0, F, F, 9'hff);
			sw(`FSAL_OFS_STORE_CTRL, 8'h01);
			tr(F, MX, 16'h0, 16'hfd00, 8'h11, F, F, DC);
			tr(F, MC, 16'h0, 16'hfd00, 8'h0, F, F, 9'h11);
		end
	endtask
	task automatic t_scratch;
		begin
			sw(`FSAL_OFS_STORE_CTRL, 8'h05);
			tr(F, MX, 16'h0, 16'h0010, 8'h12, F, F, DC);
			tr(F, MC, 16'h0, 16'h0010, 8'h0, F, F, 9'h12);
			tr(F, FE, 16'h0, 16'h0010, 8'h0, F, F, pt(16'h0010));
			sw(`FSAL_OFS_STORE_CTRL, 8'h01);
			tr(F, MC, 16'h0, 16'h0010, 8'h0, F, F, pt(16'h0010));
		end
	endtask
	task automatic t_limit;
		begin
			slow_q <= 1'h1; // Slow flash answers here
			sw(`FSAL_OFS_ACCESS_LIMIT, 8'h40);
			sw(`FSAL_OFS_ACCESS_LIMIT, 8'h80);
			rg(`FSAL_OFS_ACCESS_LIMIT, 8'h40);
			tr(F, MC, 16'h5000, 16'h3fff, 8'h0, F, T, 9'h0);
			tr(F, MC, 16'h5000, 16'h6000, 8'h0, F, F, 9'h60);
			tr(F, MC, 16'h3f00, 16'h1000, 8'h0, F, F, 9'h10);
			tr(F, FE, 16'h5000, 16'h1000, 8'h0, F, F, 9'h10);
			tr(F, MX, 16'h5000, 16'h3000, 8'h0, F, T, DC);
			slow_q <= 1'h0;
		end
	endtask
	task automatic t_erase;
		begin
			tr(T, ER, 16'h0, 16'hfdff, 8'h0, F, F, DC);
			tr(T, RD, 16'h0, 16'h0100, 8'h0, F, F, 9'hff);
			tr(T, WR, 16'h0, 16'hfdff, 8'h7f, F, F, DC);
			tr(T, ER, 16'h0, 16'hfc10, 8'h0, F, F, DC);
			tr(T, RD, 16'h0, 16'hfdff, 8'h0, F, F, 9'hff);
			rst_in <= 1'h1;
			repeat (2) @(posedge core_clk_in);
			rst_in <= 1'h0;
			rg(`FSAL_OFS_ACCESS_LIMIT, 8'h00);
			sw(`FSAL_OFS_ACCESS_LIMIT, 8'h10);
			rg(`FSAL_OFS_ACCESS_LIMIT, 8'h10);
		end
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge core_clk_in);
		rst_in <= 1'h0;
		t_regs;
		t_jtag;
		t_sw;
		t_scratch;
		t_limit;
		t_erase;
		report_and_stop;
	end
endmodule
